/* design/swc_pin_change.sv */
`timescale 1ns/10ps
// ============================================================
// pin change detector: compares live pins with last port read
module swc_pin_change import swc_pkg::*; #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinLevel,
    input  wire logic             portAccess,
    output logic                  mismatch
);
    logic [WIDTH-1:0] refLevel_ff;

    // reference captured on each file or bit operation on the port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            refLevel_ff <= '0;
        end else if (portAccess) begin
            refLevel_ff <= pinLevel;
        end
    end

    // combinational so a stale mismatch wakes at once
    assign mismatch = |(pinLevel ^ refLevel_ff); // RULE15
endmodule // swc_pin_change

/* design/swc_pkg.sv */
package swc_pkg;
    // ============================================================
    // status flag positions in the core's status byte
    localparam int          TIMEOUT_BIT   = 4;
    localparam int          POWERDOWN_BIT = 3;
    // ============================================================
    // timing, clock 25 MHz
    localparam int          CLK_HZ        = 25000000;
    localparam int          WDT_PERIOD_US = 18000;
    localparam int          WDT_CYCLES    = (CLK_HZ / 1000000) * WDT_PERIOD_US;
    localparam int          DRT_POR_US    = 18000;
    localparam int          DRT_POR_CYC   = (CLK_HZ / 1000000) * DRT_POR_US;
    localparam int          DRT_SUB_US    = 300;
    localparam int          DRT_SUB_CYC   = (CLK_HZ / 1000000) * DRT_SUB_US;
    localparam int          CNT_W         = 24;
    localparam int          PRE_W         = 7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    // ============================================================
    // sequencer states
    typedef enum logic [1:0] {
        SWC_HOLD  = 2'b00,
        SWC_RUN   = 2'b01,
        SWC_SLEEP = 2'b10
    } swc_state_t;
endpackage

/* design/swc_sleep_wakeup.sv */
`timescale 1ns/10ps
// Contract
// RULE1: sleep entered only by sleep instruction
// RULE2: sleep clears watchdog, keeps it counting
// RULE3: sleep sets active-low time-out flag
// RULE4: sleep clears active-low power-down flag
// RULE5: sleep stops main oscillator driver
// RULE6: pins hold their drive state in sleep
// RULE7: watchdog reset never pulls master-clear pin
// RULE8: master-clear wakes when pin is master-clear
// RULE9: watchdog wake only when watchdog enabled
// RULE10: pin 0, 1, 3 change wakes if enabled
// RULE11: every wake causes full device reset
// RULE12: watchdog time-out clears time-out flag
// RULE13: power-up sets power-down flag
// RULE14: pin-wake flag set on change in sleep
// RULE15: compare pins against last port read
// RULE16: software reads port before sleeping
// RULE17: watchdog cleared on every wake
// RULE18: flags encode the reset cause
// RULE19: flags hold; bare master-clear changes nothing
// RULE20: watchdog time-out starts startup hold timer
// RULE21: sleep clears prescaler assigned to watchdog
// RULE22: wake path works without processor clock
module swc_sleep_wakeup import swc_pkg::*; #(
    parameter int WDT_CYC     = WDT_CYCLES,
    parameter int DRT_POR     = DRT_POR_CYC,
    parameter int DRT_SUB     = DRT_SUB_CYC,
    parameter bit SHORT_DRT   = 1'b1
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       sleepExec,
    input  wire logic       clearWdtExec,
    input  wire logic       watchdogEnable,
    input  wire logic       masterClearEnable,
    input  wire logic       wakeOnChangeEnable,
    input  wire logic       prescalerToWdt,
    input  wire logic [2:0] prescaleSel,
    input  wire logic       masterClearPin_n,
    input  wire logic       port_pin_0,
    input  wire logic       port_pin_1,
    input  wire logic       port_pin_3,
    input  wire logic       portAccess,
    input  wire logic [5:0] pinOutCore,
    input  wire logic [5:0] pinOeCore_n,
    output logic [5:0]      pinOut,
    output logic [5:0]      pinOe_n,
    output logic            masterClearOut,
    output logic            masterClearOe_n,
    output logic            coreClockEnable,
    output logic            coreReset,
    output logic            timeout_flag_n,
    output logic            powerdown_flag_n,
    output logic            pin_wake_flag,
    output logic            sleeping,
    output logic [CNT_W-1:0] watchdog_counter
);
    // ============================================================
    // state
    swc_state_t      state_ff;
    swc_state_t      nxt_state;
    logic [CNT_W-1:0] drt_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [5:0]      heldOut_ff;
    logic [5:0]      heldOe_ff;
    logic            toFlag_ff;
    logic            pdFlag_ff;
    logic            pwFlag_ff;
    logic            pinMismatch;
    logic            preTick;
    logic            wdtTimeout;
    logic            mclrWake;
    logic            pinWake;
    logic            anyReset;
    logic [PRE_W-1:0] preMask;

    // ============================================================
    // pin change detect, pins 0,1,3 (pin 3 only when general input)
    swc_pin_change #(.WIDTH(3)) u_pin_change (
        .clock      (clock),
        .rst_n      (rst_n),
        .pinLevel   ({port_pin_3 & ~masterClearEnable, port_pin_1, port_pin_0}),
        .portAccess (portAccess),
        .mismatch   (pinMismatch)
    );

    // ============================================================
    // wake and reset sources; no core clock used on this path
    assign mclrWake = masterClearEnable && !masterClearPin_n; // RULE8
    assign pinWake  = (state_ff == SWC_SLEEP) && wakeOnChangeEnable
                      && pinMismatch; // RULE10 RULE22
    assign anyReset = mclrWake || wdtTimeout
                      || pinWake; // RULE11

    // ============================================================
    // watchdog prescaler: 2^sel divide when assigned to watchdog
    assign preMask = prescalerToWdt ? PRE_W'((8'h01 << prescaleSel) - 8'h01) : '0;
    assign preTick = ((pre_ff & preMask) == preMask);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= '0;
        end else if (sleepExec || clearWdtExec || anyReset) begin
            pre_ff <= '0; // RULE21
        end else if (watchdogEnable) begin
            pre_ff <= pre_ff + PRE_W'(1);
        end
    end

    // watchdog counts during sleep too; own timing, not core clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_counter <= CNT_ZERO;
        end else if (!watchdogEnable) begin
            watchdog_counter <= CNT_ZERO;
        end else if ((state_ff == SWC_RUN && sleepExec) || clearWdtExec) begin
            watchdog_counter <= CNT_ZERO; // RULE2
        end else if (state_ff == SWC_SLEEP && (mclrWake || pinWake)) begin
            watchdog_counter <= CNT_ZERO; // RULE17
        end else if (wdtTimeout) begin
            watchdog_counter <= CNT_ZERO; // RULE17
        end else if (preTick) begin
            watchdog_counter <= watchdog_counter + CNT_W'(1);
        end
    end

    assign wdtTimeout = watchdogEnable
                        && (watchdog_counter == CNT_W'(WDT_CYC - 1))
                        && preTick; // RULE9

    // ============================================================
    // sequencer: hold (startup timer), run, sleep
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SWC_HOLD: begin
                if (drt_ff == CNT_ZERO && !mclrWake) begin
                    nxt_state = SWC_RUN;
                end
            end
            SWC_RUN: begin
                if (anyReset) begin
                    nxt_state = SWC_HOLD;
                end else if (sleepExec) begin
                    nxt_state = SWC_SLEEP; // RULE1
                end
            end
            SWC_SLEEP: begin
                if (anyReset) begin
                    nxt_state = SWC_HOLD; // RULE11
                end
            end
            default: begin
                nxt_state = SWC_HOLD;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SWC_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // startup hold timer: long after power-up, reloaded on resets
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drt_ff <= CNT_W'(DRT_POR);
        end else if (wdtTimeout) begin
            drt_ff <= SHORT_DRT ? CNT_W'(DRT_SUB) : CNT_W'(DRT_POR); // RULE20
        end else if (anyReset && state_ff != SWC_HOLD) begin
            drt_ff <= SHORT_DRT ? CNT_W'(DRT_SUB) : CNT_W'(DRT_POR);
        end else if (state_ff == SWC_HOLD && drt_ff != CNT_ZERO && !mclrWake) begin
            drt_ff <= drt_ff - CNT_W'(1);
        end
    end

    // ============================================================
    // cause flags; only reset events, sleep and clear-watchdog change them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            toFlag_ff <= 1'b1;
            pdFlag_ff <= 1'b1; // RULE13
        end else if (wdtTimeout) begin
            toFlag_ff <= 1'b0; // RULE12 RULE18
        end else if (state_ff == SWC_RUN && sleepExec && !anyReset) begin
            toFlag_ff <= 1'b1; // RULE3
            pdFlag_ff <= 1'b0; // RULE4
        end else if (state_ff == SWC_SLEEP && (mclrWake || pinWake)) begin
            toFlag_ff <= 1'b1; // RULE18
        end else if (clearWdtExec && state_ff == SWC_RUN) begin
            toFlag_ff <= 1'b1;
            pdFlag_ff <= 1'b1;
        end
    end

    // pin-wake flag: set on wake by change, cleared by other wake causes;
    // a bare master-clear while running leaves it alone
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwFlag_ff <= 1'b0;
        end else if (pinWake && !mclrWake && !wdtTimeout) begin
            pwFlag_ff <= 1'b1; // RULE14
        end else if (wdtTimeout || (state_ff == SWC_SLEEP && mclrWake)) begin
            pwFlag_ff <= 1'b0; // RULE18 RULE19
        end
    end

    assign timeout_flag_n   = toFlag_ff;
    assign powerdown_flag_n = pdFlag_ff;
    assign pin_wake_flag    = pwFlag_ff;

    // ============================================================
    // pin hold: snapshot drive state when sleep is taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            heldOut_ff <= '0;
            heldOe_ff  <= 6'h3F;
        end else if (state_ff != SWC_SLEEP) begin
            heldOut_ff <= pinOutCore;
            heldOe_ff  <= pinOeCore_n;
        end
    end

    // in sleep the snapshot drives; core outputs are ignored
    assign pinOut  = (state_ff == SWC_SLEEP) ? heldOut_ff : pinOutCore; // RULE6
    assign pinOe_n = (state_ff == SWC_SLEEP) ? heldOe_ff : pinOeCore_n; // RULE6

    // ============================================================
    // core controls
    assign coreClockEnable = (state_ff == SWC_RUN); // RULE5
    assign coreReset       = (state_ff == SWC_HOLD) || mclrWake; // RULE11
    assign sleeping        = (state_ff == SWC_SLEEP);
    // watchdog reset stays inside: master-clear pin never driven
    assign masterClearOut  = 1'b1;
    assign masterClearOe_n = 1'b1; // RULE7
endmodule // swc_sleep_wakeup

/* verification/swc_core_model.sv */
`timescale 1ns/10ps
// ==========
// processor core stand-in: clears, reads port, then sleeps
module swc_core_model (
    input wire logic   clock,
    input wire logic   rst_n,
    input wire logic   coreClockEnable,
    input wire logic   coreReset,
    input wire logic   goSleep,
    output logic       sleepExec,
    output logic       clearWdtExec,
    output logic       portAccess,
    output logic [5:0] pinOutCore,
    output logic [5:0] pinOeCore_n
);
    logic [1:0] stepFf;
    assign pinOeCore_n = 6'h30;
    // pad data keeps moving so a held pad is really held
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinOutCore <= 6'h15;
            {stepFf, sleepExec, clearWdtExec, portAccess} <= 5'h00;
        end else begin
            pinOutCore <= ~pinOutCore;
            {sleepExec, clearWdtExec, portAccess} <= 3'h0;
            if (coreReset || !coreClockEnable) begin
                if (coreReset) stepFf <= 2'h0;
            end else if (stepFf == 2'h0 && goSleep) begin
                {clearWdtExec, portAccess} <= 2'h3;
                stepFf <= 2'h1;
            end else if (stepFf == 2'h1) begin
                sleepExec <= 1'b1;
                stepFf <= 2'h2;
            end
        end
    end
endmodule // swc_core_model

/* verification/swc_sleep_asserts.sv */
`timescale 1ns/10ps
// ==========
// sleep and wake checker, sees top ports only
module swc_sleep_asserts import swc_pkg::*; (
    input wire logic             clock,
    input wire logic             rst_n,
    input wire logic             sleepExec,
    input wire logic             watchdogEnable,
    input wire logic [5:0]       pinOut,
    input wire logic [5:0]       pinOe_n,
    input wire logic             masterClearOe_n,
    input wire logic             coreReset,
    input wire logic             timeout_flag_n,
    input wire logic             powerdown_flag_n,
    input wire logic             pin_wake_flag,
    input wire logic             sleeping,
    input wire logic [CNT_W-1:0] watchdog_counter
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // entry, flags and pads while asleep
    AST_SLEEP_CAUSE: assert property ($rose(sleeping) |-> $past(sleepExec))
        else $error("sleep without instruction");
    AST_SLEEP_FLAGS: assert property ($rose(sleeping) |-> timeout_flag_n &&
        !powerdown_flag_n && watchdog_counter == CNT_ZERO) else $error("bad sleep entry");
    AST_PAD_HOLD: assert property (sleeping && $past(sleeping) |-> $stable(pinOut)
        && $stable(pinOe_n)) else $error("pads moved in sleep");
    AST_MASTER_CLEAR_PIN_QUIET: assert property (masterClearOe_n) else $error("master_clear_pin driven");
    // wake consequences
    AST_WDT_GATE: assert property ($fell(timeout_flag_n) |-> watchdogEnable)
        else $error("time-out while disabled");
    AST_WAKE_RESET: assert property ($fell(sleeping) |-> coreReset)
        else $error("wake without reset");
    AST_PIN_FLAG: assert property ($rose(pin_wake_flag) |-> $past(sleeping))
        else $error("pin flag outside sleep");
    AST_WAKE_CLEAR: assert property ($fell(sleeping) |-> ##[0:1] watchdog_counter == CNT_ZERO)
        else $error("counter kept on wake");
    AST_HOLD_TIMER: assert property ($fell(timeout_flag_n) |-> ##[0:1] coreReset[*8])
        else $error("no hold after time-out");
endmodule // swc_sleep_asserts
bind swc_sleep_wakeup swc_sleep_asserts chk_u (.clock, .rst_n, .sleepExec, .watchdogEnable,
    .pinOut, .pinOe_n, .masterClearOe_n, .coreReset, .timeout_flag_n, .powerdown_flag_n,
    .pin_wake_flag, .sleeping, .watchdog_counter);

/* verification/tb_top.sv */
`timescale 1ns/10ps
// ==========
// sleep and wake bench, one task per scenario
module tb_top import swc_pkg::*; ;
    logic clock, rst_n, sleepExec, clearWdtExec, portAccess, goSleep, masterClearPin_n;
    logic watchdogEnable, masterClearEnable, wakeOnChangeEnable, prescalerToWdt;
    logic port_pin_0, port_pin_1, port_pin_3, masterClearOut, masterClearOe_n;
    logic coreClockEnable, coreReset, timeout_flag_n, powerdown_flag_n, pin_wake_flag;
    logic sleeping;
    logic [2:0] prescaleSel, cause;
    logic [5:0] pinOutCore, pinOeCore_n, pinOut, pinOe_n, heldOut;
    logic [CNT_W-1:0] watchdog_counter;
    int errCount, checkCount;
    assign cause = {pin_wake_flag, timeout_flag_n, powerdown_flag_n};
    swc_sleep_wakeup #(.WDT_CYC(20), .DRT_POR(30), .DRT_SUB(10)) dut_u (.clock, .rst_n,
        .sleepExec, .clearWdtExec, .watchdogEnable, .masterClearEnable, .wakeOnChangeEnable,
        .prescalerToWdt, .prescaleSel, .masterClearPin_n, .port_pin_0, .port_pin_1,
        .port_pin_3, .portAccess, .pinOutCore, .pinOeCore_n, .pinOut, .pinOe_n,
        .masterClearOut, .masterClearOe_n, .coreClockEnable, .coreReset, .timeout_flag_n,
        .powerdown_flag_n, .pin_wake_flag, .sleeping, .watchdog_counter);
    swc_core_model core_u (.clock, .rst_n, .coreClockEnable, .coreReset, .goSleep,
        .sleepExec, .clearWdtExec, .portAccess, .pinOutCore, .pinOeCore_n);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    // bounded wait for sleep or for the core running again
    task automatic waitFor(input logic wantSleep);
        int n;
        n = 0;
        while ((wantSleep ? sleeping : coreClockEnable) !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        if (n == 300) errCount++;
    endtask
    task automatic enterSleep;
        @(posedge clock) goSleep <= 1'b1;
        waitFor(1'b1);
        @(posedge clock) goSleep <= 1'b0;
        @(negedge clock);
    endtask
    task automatic testPowerUp;
        waitFor(1'b0);
        check(cause, 3'b011);
    endtask
    // watchdog off: sleep must last, then a pin change wakes
    task automatic testSleepPin;
        enterSleep;
        check({timeout_flag_n, powerdown_flag_n, coreClockEnable}, 3'b100);
        heldOut = pinOut;
        repeat (40) @(negedge clock);
        check({sleeping, coreReset, 1'b0}, 3'b100);
        check({1'b0, pinOut === heldOut, pinOe_n === 6'h30}, 3'b011);
        @(posedge clock) {port_pin_0, port_pin_1} <= 2'h2;
        waitFor(1'b0);
        check(cause, 3'b110);
    endtask
    // bare master-clear pulse while running, then one that wakes
    task automatic mclrPulse;
        @(posedge clock) masterClearPin_n <= 1'b0;
        repeat (3) @(posedge clock);
        masterClearPin_n <= 1'b1;
        waitFor(1'b0);
    endtask
    task automatic testMclr;
        mclrPulse;
        check(cause, 3'b110);
        enterSleep;
        mclrPulse;
        check(cause, 3'b010);
    endtask
    // prescaled watchdog wake; a pin change with wake-on-change off is ignored
    task automatic testWdtWake;
        @(posedge clock) {watchdogEnable, prescalerToWdt, wakeOnChangeEnable} <= 3'h6;
        prescaleSel <= 3'h1;
        enterSleep;
        check({masterClearOut, masterClearOe_n, 1'b0}, 3'b110);
        check({2'b00, watchdog_counter < CNT_W'(20)}, 3'b001);
        @(posedge clock) port_pin_1 <= 1'b1;
        waitFor(1'b0);
        check(cause, 3'b000);
        @(posedge clock) {watchdogEnable, wakeOnChangeEnable} <= 2'h1;
    endtask
    task automatic completeRun;
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog: whole run needs well under 3000 cycles
    initial begin
        #(40 * 3000);
        errCount++;
        completeRun;
    end
    initial begin
        {rst_n, goSleep, watchdogEnable, prescalerToWdt, port_pin_0, port_pin_1} = 6'h00;
        {masterClearEnable, wakeOnChangeEnable, masterClearPin_n, port_pin_3} = 4'hF;
        prescaleSel = 3'h0;
        {errCount, checkCount} = {32'sd0, 32'sd0};
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        testPowerUp;
        testSleepPin;
        testMclr;
        testWdtWake;
        completeRun;
    end
endmodule // tb_top
